// File: include/step_input_consts.vh
// step_input_consts.vh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from the rtl files, 100 MHz system clock
`ifndef STEP_INPUT_CONSTS_VH
`define STEP_INPUT_CONSTS_VH

// ----------------------------------------------------------------
// register offsets (word addresses on the plain register port)
// ----------------------------------------------------------------
`define ADDR_CONTROL      4'h0
`define ADDR_RESOLUTION   4'h1
`define ADDR_CURRENT      4'h2
`define ADDR_POSITION     4'h3
`define ADDR_STATUS       4'h4
`define ADDR_STEP_COUNT   4'h5

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define CTRL_CLEAR_BIT    0
`define STAT_OUT_EN_BIT   0
`define STAT_DIR_BIT      1
`define STAT_LAST_DIR_BIT 2
`define RES_WIDTH         4
`define RES_RESET         4'h0
`define RUN_CUR_RESET     8'h80
`define HOLD_CUR_RESET    8'h40
`define POS_WIDTH         16
`define POS_RESET         16'h0000
`define CW_RESET          1'b1
`define OUT_EN_RESET      1'b1
`define COUNT_RESET       16'h0000
`define CUR_OFF           8'h00

// ----------------------------------------------------------------
// timing: the controller's step limits, in ns and kHz, and derived cycles
// ----------------------------------------------------------------
`define CLOCK_PERIOD_NS   10
`define STEP_MIN_PULSE_NS 400
`define STEP_MAX_FREQ_KHZ 2000
`define STEP_MIN_PULSE_CYC (`STEP_MIN_PULSE_NS / `CLOCK_PERIOD_NS)
`define STEP_MIN_PERIOD_CYC (1000000 / (`STEP_MAX_FREQ_KHZ * `CLOCK_PERIOD_NS))

`endif

// File: rtl/pin_sync.v
// pin_sync.v: three-flop synchroniser with agreement filter for one pin
// assumes: pin is asynchronous to clock; output changes once stages 2 and 3 agree

module pin_sync #(
   parameter RESET_LEVEL = 1'b1
) (
   // clock and reset
   input  wire clock,
   input  wire rst,
   // pin and filtered level
   input  wire pin,
   output reg  level_q
);

   reg s1_q;
   reg s2_q;
   reg s3_q;

   always @(posedge clock) begin
      if (rst) begin
         s1_q    <= RESET_LEVEL;
         s2_q    <= RESET_LEVEL;
         s3_q    <= RESET_LEVEL;
         level_q <= RESET_LEVEL;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // s1 is only read by s2; the filter looks at s2 and s3
         if (s2_q == s3_q) begin
            level_q <= s3_q;
         end
      end
   end

endmodule // pin_sync

// File: rtl/step_dir_enable_input_logic.v
// step_dir_enable_input_logic.v: step, direction and enable input logic of a
// microstepping driver, with position generator and phase-current outputs
// assumes: pins come straight from the isolated inputs, pulled high when open;
// register port master follows one-cycle strobes, read data one cycle later
//
// Our own choices: the register addresses and the strobed register port.
`include "step_input_consts.vh"

// Summary of operation
// [R1] enable pin high (default when open) keeps driver outputs active.
// [R2] enable pin low disables the driver output stage.
// [R3] position generator keeps counting on every step while outputs are disabled.
// [R4] enable is asynchronous to other inputs and accepted at any moment.
// [R5] step rising edge latches direction and resolution, used for that step.
// [R6] direction or resolution changes act only at the next step rising edge.
// [R7] run and hold current settings apply immediately, no step needed.
// [R8] controller keeps step pulses at least 400 ns, at most 2.0 MHz.
// [R9] each step rising edge moves position one microstep, up or down.
// [R10] direction high gives clockwise, low gives counter-clockwise.
// [R11] on re-enable outputs show the net steps taken while disabled.
module step_dir_enable_input_logic (
   // clock and reset
   input  wire        clock,
   input  wire        rst,
   // isolated logic input pins
   input  wire        step_pin,
   input  wire        dir_pin,
   input  wire        enable_pin,
   // register port
   input  wire [3:0]  addr,
   input  wire [31:0] wdata,
   input  wire        write_strobe,
   input  wire        read_strobe,
   output reg  [31:0] rdata_q,
   // driver output stage
   output reg         out_enable_q,
   output reg         clockwise_q,
   output reg  [15:0] position_q,
   output reg  [7:0]  phase_current_q,
   output reg         step_taken_q
);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   wire step_s;
   wire dir_s;
   wire enable_s;

   pin_sync #(.RESET_LEVEL(1'b0)) step_sync (
      .clock   (clock),
      .rst     (rst),
      .pin     (step_pin),
      .level_q (step_s)
   );

   pin_sync #(.RESET_LEVEL(1'b1)) dir_sync (
      .clock   (clock),
      .rst     (rst),
      .pin     (dir_pin),
      .level_q (dir_s)
   );

   // limitation: a pin pulse shorter than about two clocks may never settle
   // through the agreement filter; the controller's minimum pulse is far above it
   // enable has its own path, independent of step timing
   pin_sync #(.RESET_LEVEL(1'b1)) enable_sync (
      .clock   (clock),
      .rst     (rst),
      .pin     (enable_pin),
      .level_q (enable_s)
   ); // [R4]

   // ----------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------
   reg [`RES_WIDTH-1:0] resolution_q;
   reg [7:0]            run_current_q;
   reg [7:0]            hold_current_q;
   reg [15:0]           step_count_q;
   reg                  step_prev_q;
   reg                  last_dir_q;

   function sel;
      input [3:0] a;
      input [3:0] target;
      begin
         sel = (a == target);
      end
   endfunction

   // clear is a write pulse, not a stored bit: reading the control word gives zero
   wire clear_req = write_strobe && sel(addr, `ADDR_CONTROL) && wdata[`CTRL_CLEAR_BIT];

   always @(posedge clock) begin
      if (rst) begin
         resolution_q   <= `RES_RESET;
         run_current_q  <= `RUN_CUR_RESET;
         hold_current_q <= `HOLD_CUR_RESET;
      end else if (write_strobe) begin
         if (sel(addr, `ADDR_RESOLUTION)) begin
            resolution_q <= wdata[`RES_WIDTH-1:0];
         end
         if (sel(addr, `ADDR_CURRENT)) begin
            run_current_q  <= wdata[7:0];
            hold_current_q <= wdata[15:8];
         end
      end
   end

   // ----------------------------------------------------------------
   // step edge, latch and position generator
   // ----------------------------------------------------------------
   wire step_rise = step_s && !step_prev_q;

   // microstep size: 2**resolution; the widest setting still fits the
   // 16-bit generator, so no cap is needed
   function [15:0] step_size;
      input [`RES_WIDTH-1:0] res;
      begin
         step_size = 16'h0001 << res;
      end
   endfunction

   reg [15:0] position_d;
   reg [15:0] step_count_d;

   // counting ignores the enable on purpose, so the generator keeps
   // tracking the controller while the stage is off
   always @* begin
      position_d   = position_q;
      step_count_d = step_count_q;
      if (step_rise) begin
         if (dir_s) begin
            position_d = position_q + step_size(resolution_q);           // [R9] [R3]
         end else begin
            position_d = position_q - step_size(resolution_q);           // [R9] [R3]
         end
      end
      // a step in the clearing cycle still counts: the clear applies and the count restarts at 1
      if (step_rise) begin
         step_count_d = clear_req ? 16'h0001 : step_count_q + 16'h0001;
      end else if (clear_req) begin
         step_count_d = `COUNT_RESET;
      end
   end

   always @(posedge clock) begin
      if (rst) begin
         step_prev_q  <= 1'b0;
         position_q   <= `POS_RESET;
         clockwise_q  <= `CW_RESET;
         last_dir_q   <= `CW_RESET;
         step_taken_q <= 1'b0;
         step_count_q <= `COUNT_RESET;
      end else begin
         step_prev_q  <= step_s;
         step_taken_q <= step_rise;
         position_q   <= position_d;
         step_count_q <= step_count_d;
         // direction is stored only here, so a pin change waits for the next step
         if (step_rise) begin
            last_dir_q  <= dir_s;                                        // [R5] [R6]
            clockwise_q <= dir_s;                                        // [R10]
         end
      end
   end

   // ----------------------------------------------------------------
   // output stage
   // ----------------------------------------------------------------
   reg [7:0] phase_current_d;

   // both current registers are read live, so a new setting shows at once
   always @* begin
      if (!enable_s) begin
         phase_current_d = `CUR_OFF;                                     // [R2]
      end else if (step_rise) begin
         phase_current_d = run_current_q;                                // [R7]
      end else begin
         phase_current_d = hold_current_q;                               // [R7]
      end
   end

   // position_q is shared, so re-enabled outputs show all steps taken meanwhile
   always @(posedge clock) begin
      if (rst) begin
         out_enable_q    <= `OUT_EN_RESET;
         phase_current_q <= `CUR_OFF;
      end else begin
         out_enable_q    <= enable_s;                                    // [R1] [R2] [R11]
         phase_current_q <= phase_current_d;
      end
   end

   // ----------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------
   reg [31:0] rdata_d;

   // idle cycles return zero so a stale word is never taken for an answer
   always @* begin
      rdata_d = 32'h00000000;
      if (read_strobe) begin
         case (addr)
            `ADDR_RESOLUTION: rdata_d = {28'h0000000, resolution_q};
            `ADDR_CURRENT:    rdata_d = {16'h0000, hold_current_q, run_current_q};
            `ADDR_POSITION:   rdata_d = {16'h0000, position_q};
            `ADDR_STATUS: begin
               rdata_d[`STAT_OUT_EN_BIT]   = enable_s;
               rdata_d[`STAT_DIR_BIT]      = dir_s;
               rdata_d[`STAT_LAST_DIR_BIT] = last_dir_q;
            end
            `ADDR_STEP_COUNT: rdata_d = {16'h0000, step_count_q};
            default:          rdata_d = 32'h00000000;
         endcase
      end
   end

   always @(posedge clock) begin
      if (rst) begin
         rdata_q <= 32'h00000000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

endmodule // step_dir_enable_input_logic

// File: verif/step_input_checker.sv
// step_input_checker.sv: port assertions for the step input block
// assumes: bound to step_dir_enable_input_logic, one clock domain
module step_input_checker (
   // clock and reset
   input wire logic        clock,
   input wire logic        rst,
   // pins and outputs
   input wire logic        step_pin,
   input wire logic        enable_pin,
   input wire logic        out_enable_q,
   input wire logic        clockwise_q,
   input wire logic [15:0] position_q,
   input wire logic [7:0]  phase_current_q,
   input wire logic        step_taken_q
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   a_off_no_current: assert property (
      !out_enable_q |-> phase_current_q == 8'h00) else $error("current while disabled");
   a_pos_holds: assert property (
      !step_taken_q |-> $stable(position_q)) else $error("position moved without step");
   a_dir_holds: assert property (
      !step_taken_q |-> $stable(clockwise_q)) else $error("direction moved between steps");
   a_pulse_single: assert property (
      step_taken_q |=> !step_taken_q) else $error("step pulse too long");
   a_step_counted: assert property (
      $rose(step_pin) |-> ##[2:7] step_taken_q) else $error("step edge lost");
   a_taken_high: assert property (
      step_taken_q |-> step_pin) else $error("step taken without pin high");
   a_enable_off: assert property (
      $fell(enable_pin) |-> ##[1:8] !out_enable_q) else $error("outputs not disabled");
   a_enable_on: assert property (
      $rose(enable_pin) |-> ##[1:8] out_enable_q) else $error("outputs not enabled");
endmodule // step_input_checker

bind step_dir_enable_input_logic step_input_checker i_chk (.clock, .rst, .step_pin,
   .enable_pin, .out_enable_q, .clockwise_q, .position_q, .phase_current_q, .step_taken_q);

// File: verif/step_controller.sv
// step_controller.sv: motion controller model issuing one step pulse per request
// assumes: requests only while busy is low
module step_controller (
   // clock
   input wire logic clock,
   // request and step line
   input wire logic fire,
   output logic     step_pin,
   output logic     busy
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned cnt_q = 0;
   // 40 cycles high, at least 11 low: pulse 400 ns wide, rate never above 2.0 MHz
   always @(posedge clock) begin
      if (cnt_q == 0 && fire) cnt_q <= 50;
      else if (cnt_q != 0) cnt_q <= cnt_q - 1;
   end
   assign step_pin = cnt_q > 10;
   assign busy = cnt_q != 0;
endmodule // step_controller

// File: verif/test_step_dir_enable_input_logic.sv
// test_step_dir_enable_input_logic.sv: self-checking bench for the step input block
// assumes: step_controller drives the step pin, bench drives direction and enable
`include "step_input_consts.vh"
module test_step_dir_enable_input_logic;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock = 0, rst = 1, dir_pin = 1, enable_pin = 1, fire = 0;
   logic        write_strobe = 0, read_strobe = 0;
   logic [3:0]  addr = 4'h0, res = 4'h0;
   logic [31:0] wdata = 32'h0, v;
   logic [15:0] pos = 16'h0;
   logic [7:0]  run = `RUN_CUR_RESET, hold = `HOLD_CUR_RESET;
   wire  [31:0] rdata_q;
   wire  [15:0] position_q;
   wire  [7:0]  phase_current_q;
   wire         out_enable_q, clockwise_q, step_taken_q, step_pin, busy;
   int          failures = 0, total_checks = 0, n, steps = 0, seed = 32'hDCBF4CB0;
   step_dir_enable_input_logic i_dut (.clock, .rst, .step_pin, .dir_pin, .enable_pin,
      .addr, .wdata, .write_strobe, .read_strobe, .rdata_q, .out_enable_q, .clockwise_q,
      .position_q, .phase_current_q, .step_taken_q);
   step_controller i_ctl (.clock, .fire, .step_pin, .busy);
   always #5 clock = ~clock;
   task conclude;
      if (failures == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      addr <= a; wdata <= d; write_strobe <= 1;
      @(posedge clock); write_strobe <= 0;
      @(posedge clock);
   endtask
   task rd(input logic [3:0] a, output logic [31:0] d);
      addr <= a; read_strobe <= 1;
      @(posedge clock); read_strobe <= 0;
      #1 d = rdata_q;
      @(posedge clock);
   endtask
   function logic [15:0] next_pos(logic [15:0] p, logic d, logic [3:0] r);
      return d ? p + (16'h1 << r) : p - (16'h1 << r);
   endfunction
   // dir settles 6 cycles before the pulse so its sync path has caught up
   task step(input logic d);
      dir_pin <= d;
      repeat (6) @(posedge clock);
      fire <= 1; @(posedge clock); fire <= 0;
      for (n = 0; n < 20 && step_taken_q !== 1'b1; n++) begin @(posedge clock); #1; end
      chk(phase_current_q, enable_pin ? run : 8'h00);
      pos = next_pos(pos, d, res);
      chk(position_q, pos);
      chk(clockwise_q, d);
      steps++;
      @(posedge clock);
      #1 chk(phase_current_q, enable_pin ? hold : 8'h00);
      chk(step_taken_q, 0);
      while (busy) @(posedge clock);
   endtask
   initial begin
      repeat (6) @(posedge clock);
      rst <= 0;
      repeat (5) @(posedge clock);
      #1 chk(out_enable_q, 1);
      rd(`ADDR_CURRENT, v); chk(v, {16'h0, hold, run});
      rd(4'hF, v); chk(v, 0);
      run = 8'h5A; hold = 8'h21;
      wr(`ADDR_CURRENT, {16'h0, hold, run});
      repeat (2) @(posedge clock);
      #1 chk(phase_current_q, hold);
      for (int i = 0; i < 16; i++) begin
         if (i % 4 == 0) begin
            res = (i == 0) ? 4'hF : $random(seed);
            wr(`ADDR_RESOLUTION, {28'h0, res});
         end
         step($random(seed));
      end
      step(1); dir_pin <= 0;
      repeat (10) @(posedge clock);
      #1 chk(clockwise_q, 1);
      enable_pin <= 0;
      repeat (10) @(posedge clock);
      #1 chk(out_enable_q, 0);
      repeat (3) step(0);
      step(1);
      enable_pin <= 1;
      repeat (10) @(posedge clock);
      #1 chk(out_enable_q, 1);
      chk(position_q, pos);
      rd(`ADDR_POSITION, v);
      chk(v, {16'h0, pos});
      rd(`ADDR_STEP_COUNT, v);
      chk(v, steps);
      rd(`ADDR_STATUS, v);
      chk(v, {29'h0, 1'b1, dir_pin, enable_pin});
      wr(`ADDR_CONTROL, 32'h1);
      rd(`ADDR_STEP_COUNT, v);
      chk(v, 0);
      conclude;
   end
   initial begin
      repeat (20000) @(posedge clock);
      failures++;
      conclude;
   end
endmodule // test_step_dir_enable_input_logic
